// ### dv/recursive_temporal_denoise_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtd_defs.vh"
module recursive_temporal_denoise_tb;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] curr_d = 16'h0000;
  logic [15:0] prev_d = 16'h0000;
  logic        cv = 1'b0;
  logic        pv = 1'b0;
  logic        c_last = 1'b0;
  logic        c_user = 1'b0;
  logic        stall = 1'b0;
  logic [2:0]  bank = `STR_AGGRESSIVE;
  logic        done_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [2:0]  wr_bank = 3'h0;
  logic        wr_chroma = 1'b0;
  logic [5:0]  wr_idx = 6'h00;
  logic [7:0]  wr_data = 8'h00;
  wire logic   c_rdy, p_rdy, rdy, mem_v, done;
  wire logic [15:0] mem_d, mot_d;
  logic [15:0] curr_a[8];
  logic [15:0] prev_a[8];
  logic [15:0] exp_a[8];
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  int          done_cnt = 0;
  recursive_temporal_denoise #(.INIT_STRENGTH(`STR_AGGRESSIVE))
    i_recursive_temporal_denoise
  (
    .mclk_i(mclk_i), .rst_i(rst_i), .curr_tdata_i(curr_d),
    .curr_tvalid_i(cv), .curr_tlast_i(c_last), .curr_tuser_i(c_user),
    .curr_tready_o(c_rdy), .prev_tdata_i(prev_d), .prev_tvalid_i(pv),
    .prev_tready_o(p_rdy), .mem_tdata_o(mem_d), .mem_tvalid_o(mem_v),
    .mem_tlast_o(), .mem_tuser_o(), .mem_tready_i(rdy),
    .video_tdata_o(), .video_tvalid_o(), .video_tlast_o(),
    .video_tuser_o(), .video_tready_i(rdy), .motion_tdata_o(mot_d),
    .motion_tvalid_o(), .motion_tlast_o(), .motion_tuser_o(),
    .motion_tready_i(rdy), .active_bank_i(bank),
    .curve_wr_en_i(wr_en), .curve_wr_bank_i(wr_bank),
    .curve_wr_chroma_i(wr_chroma), .curve_wr_idx_i(wr_idx),
    .curve_wr_data_i(wr_data), .frame_done_en_i(done_en),
    .frame_done_o(done)
  );
  video_sink_model i_video_sink_model
  (
    .mclk_i(mclk_i), .stall_i(stall), .mem_tdata_i(mem_d),
    .mem_tvalid_i(mem_v), .motion_tdata_i(mot_d), .tready_o(rdy)
  );
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles++;
    if (done === 1'b1)
      done_cnt++;
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One line of eight pairs; previous stream may trail by lag cycles
  task automatic run_frame(input int lag);
    int t;
    i_video_sink_model.pix_q.delete();
    i_video_sink_model.mot_q.delete();
    done_cnt = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk_i);
      curr_d = curr_a[i];
      c_user = (i == 0);
      c_last = (i == 7);
      cv = 1'b1;
      if (lag > 0)
      begin
        pv = 1'b0;
        prev_d = ~prev_d;
        repeat (lag) @(negedge mclk_i);
      end
      prev_d = prev_a[i];
      pv = 1'b1;
      #1;
      t = 0;
      while (!(c_rdy && p_rdy) && t < 200)
      begin
        @(negedge mclk_i);
        #1;
        t++;
      end
      @(posedge mclk_i);
    end
    @(negedge mclk_i);
    cv = 1'b0;
    pv = 1'b0;
    curr_d = ~curr_d;
    prev_d = ~prev_d;
    bank = `STR_NONE;
    t = 0;
    while (i_video_sink_model.pix_q.size() < 8 && t < 400)
    begin
      @(negedge mclk_i);
      t++;
    end
    check(16'(i_video_sink_model.pix_q.size()), 16'h0008);
    for (int i = 0; i < 8 && i < i_video_sink_model.pix_q.size(); i++)
      check(i_video_sink_model.pix_q[i], exp_a[i]);
  endtask
  task automatic write_curve(input logic [2:0] b, input logic ch,
                             input logic [7:0] v);
    for (int i = 0; i < 64; i++)
    begin
      @(negedge mclk_i);
      wr_en = 1'b1;
      wr_bank = b;
      wr_chroma = ch;
      wr_idx = i[5:0];
      wr_data = (i == 63) ? 8'h00 : v;
    end
    @(negedge mclk_i);
    wr_en = 1'b0;
  endtask
  task automatic sc_still;
    bank = `STR_AGGRESSIVE;
    done_en = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      curr_a[i] = {8'h90 - 8'(i), 8'h30 + 8'(i)};
      prev_a[i] = curr_a[i];
      exp_a[i] = curr_a[i];
    end
    run_frame(2);
    for (int i = 0; i < 8; i++)
      check(i_video_sink_model.mot_q[i], 16'h0000);
    check(16'(done_cnt), 16'h0001);
  endtask
  task automatic sc_max_motion;
    bank = `STR_AGGRESSIVE;
    done_en = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      curr_a[i] = 16'h00FF;
      prev_a[i] = 16'hFF00;
      exp_a[i] = 16'h00FF;
    end
    run_frame(0);
    check(16'(done_cnt), 16'h0000);
  endtask
  task automatic sc_bypass;
    bank = `STR_NONE;
    for (int i = 0; i < 8; i++)
    begin
      curr_a[i] = {8'h40, 8'h20 + 8'(i)};
      prev_a[i] = {8'h10 + 8'(i), 8'hC0};
      exp_a[i] = curr_a[i];
    end
    run_frame(1);
  endtask
  // Custom bank: luma full recursion, chroma none, sink stalling; then a bank 4 bypass frame, sink not stalling
  task automatic sc_custom;
    write_curve(3'h5, 1'b0, 8'hFF);
    write_curve(3'h5, 1'b1, 8'h00);
    bank = 3'h5;
    stall = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      curr_a[i] = 16'h4080;
      prev_a[i] = 16'h5090;
      exp_a[i] = 16'h4090;
    end
    run_frame(0);
    stall = 1'b0;
    for (int i = 0; i < 8; i++)
      exp_a[i] = 16'h4080;
    run_frame(0);
  endtask
  task automatic sc_reset;
    @(negedge mclk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    check({15'h0000, mem_v}, 16'h0000);
  endtask
  initial
  begin
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    sc_still();
    sc_max_motion();
    sc_bypass();
    sc_custom();
    sc_reset();
    sc_bypass();
    stop_test();
  end
endmodule
`default_nettype wire

// ### dv/rtd_stream_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rtd_stream_chk
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        curr_tvalid_i,
  input  wire logic        prev_tvalid_i,
  input  wire logic        curr_tready_o,
  input  wire logic        prev_tready_o,
  input  wire logic [15:0] mem_tdata_o,
  input  wire logic        mem_tvalid_o,
  input  wire logic [15:0] video_tdata_o,
  input  wire logic        video_tvalid_o,
  input  wire logic [15:0] motion_tdata_o,
  input  wire logic        motion_tvalid_o,
  input  wire logic        mem_tlast_o,
  input  wire logic        video_tlast_o,
  input  wire logic        motion_tlast_o,
  input  wire logic        mem_tuser_o,
  input  wire logic        video_tuser_o,
  input  wire logic        motion_tuser_o,
  input  wire logic        mem_tready_i,
  input  wire logic        video_tready_i,
  input  wire logic        motion_tready_i,
  input  wire logic        frame_done_en_i,
  input  wire logic        frame_done_o
);
  wire logic       all_rdy;
  wire logic       take;
  logic      [3:0] inflight_r;
  assign all_rdy = mem_tready_i && video_tready_i && motion_tready_i;
  assign take = curr_tvalid_i && prev_tvalid_i && curr_tready_o
                && prev_tready_o;
  // Pairs taken but not yet handed out
  always @(posedge mclk_i)
    if (rst_i)
      inflight_r <= 4'h0;
    else
      inflight_r <= inflight_r + {3'h0, take}
                    - {3'h0, mem_tvalid_o && all_rdy};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence take_s;
    curr_tvalid_i && prev_tvalid_i && curr_tready_o && prev_tready_o;
  endsequence
  sequence stall_s;
    mem_tvalid_o && !all_rdy;
  endsequence
  AST_COPY: assert property (mem_tvalid_o |-> video_tdata_o == mem_tdata_o)
    else $error("video copy differs from memory stream");
  AST_FRAMING_COPY: assert property (mem_tvalid_o |->
    video_tlast_o == mem_tlast_o && motion_tlast_o == mem_tlast_o
    && video_tuser_o == mem_tuser_o && motion_tuser_o == mem_tuser_o)
    else $error("framing flags differ between output streams");
  AST_VALID_SYNC: assert property (mem_tvalid_o == video_tvalid_o
    && mem_tvalid_o == motion_tvalid_o)
    else $error("output streams out of step");
  AST_HOLD: assert property (stall_s |=> mem_tvalid_o
    && $stable(mem_tdata_o) && $stable(motion_tdata_o))
    else $error("output beat changed while stalled");
  AST_NO_SPURIOUS: assert property (mem_tvalid_o |-> inflight_r != 4'h0)
    else $error("output beat without an input pair");
  AST_CAPACITY: assert property (inflight_r <= 4'h6)
    else $error("inputs accepted while outputs stalled");
  AST_PAIR_RDY: assert property (curr_tvalid_i && prev_tvalid_i |->
    curr_tready_o == prev_tready_o)
    else $error("input streams not taken together");
  AST_LATENCY: assert property (take_s |-> ##[2:20] mem_tvalid_o)
    else $error("no output after input pair");
  AST_RESET: assert property ($fell(rst_i) |-> !mem_tvalid_o
    && !motion_tvalid_o && !frame_done_o)
    else $error("outputs active after reset");
  AST_DONE_MASK: assert property (frame_done_o |-> $past(frame_done_en_i))
    else $error("frame done while masked");
  AST_DONE_PULSE: assert property (frame_done_o |=> !frame_done_o)
    else $error("frame done longer than one cycle");
endmodule
bind recursive_temporal_denoise rtd_stream_chk i_rtd_stream_chk
(
  .mclk_i, .rst_i, .curr_tvalid_i, .prev_tvalid_i, .curr_tready_o,
  .prev_tready_o, .mem_tdata_o, .mem_tvalid_o, .video_tdata_o,
  .video_tvalid_o, .motion_tdata_o, .motion_tvalid_o, .mem_tlast_o,
  .video_tlast_o, .motion_tlast_o, .mem_tuser_o, .video_tuser_o,
  .motion_tuser_o, .mem_tready_i,
  .video_tready_i, .motion_tready_i, .frame_done_en_i, .frame_done_o
);
`default_nettype wire

// ### dv/video_sink_model.sv
`timescale 1ns/10ps
`default_nettype none
module video_sink_model
(
  input  wire logic        mclk_i,
  input  wire logic        stall_i,
  input  wire logic [15:0] mem_tdata_i,
  input  wire logic        mem_tvalid_i,
  input  wire logic [15:0] motion_tdata_i,
  output var  logic        tready_o
);
  logic [15:0] pix_q[$];
  logic [15:0] mot_q[$];
  logic [3:0]  cnt_r;
  initial
  begin
    tready_o = 1'b1;
    cnt_r = 4'h0;
  end
  // Slow sink holds ready low for 8 of every 10 cycles
  always @(negedge mclk_i)
  begin
    cnt_r = (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
    tready_o = !stall_i || cnt_r > 4'h7;
  end
  always @(posedge mclk_i)
    if (mem_tvalid_i && tready_o)
    begin
      pix_q.push_back(mem_tdata_i);
      mot_q.push_back(motion_tdata_i);
    end
endmodule
`default_nettype wire

// ### rtl/curve_mem.v
`timescale 1ns/10ps
`default_nettype none
`include "rtd_defs.vh"

module curve_mem
#(
  parameter [2:0] INIT_STRENGTH = `STR_AGGRESSIVE
)
(
  input  wire        mclk_i,
  input  wire        wr_en_i,
  input  wire [2:0]  wr_bank_i,
  input  wire        wr_chroma_i,
  input  wire [5:0]  wr_idx_i,
  input  wire [7:0]  wr_data_i,
  input  wire [2:0]  rd_bank_i,
  input  wire [5:0]  rd_luma_idx_i,
  input  wire [5:0]  rd_chroma_idx_i,
  output reg  [7:0]  rd_luma_o,
  output reg  [7:0]  rd_chroma_o
);

  reg [7:0] luma_mem   [0:511];
  reg [7:0] chroma_mem [0:511];

  function [7:0] base_curve;
    input [5:0] idx;
    begin
      case (idx)
        6'h00: base_curve = 8'hFF;
        6'h01: base_curve = 8'hFA;
        6'h02: base_curve = 8'hC8;
        6'h03: base_curve = 8'hA0;
        6'h04: base_curve = 8'h64;
        6'h05: base_curve = 8'h41;
        6'h06: base_curve = 8'h32;
        6'h07: base_curve = 8'h28;
        6'h08: base_curve = 8'h24;
        6'h09: base_curve = 8'h1E;
        6'h0A: base_curve = 8'h1C;
        6'h0B: base_curve = 8'h19;
        6'h0C: base_curve = 8'h17;
        6'h0D: base_curve = 8'h15;
        6'h0E: base_curve = 8'h13;
        6'h0F: base_curve = 8'h12;
        6'h10: base_curve = 8'h11;
        6'h11: base_curve = 8'h10;
        6'h12: base_curve = 8'h0F;
        6'h13: base_curve = 8'h0E;
        6'h14: base_curve = 8'h0D;
        6'h15, 6'h16: base_curve = 8'h0C;
        6'h17, 6'h18: base_curve = 8'h0B;
        6'h19, 6'h1A, 6'h1B, 6'h1C: base_curve = 8'h0A;
        6'h1D, 6'h1E, 6'h1F, 6'h20: base_curve = 8'h09;
        6'h21, 6'h22, 6'h23: base_curve = 8'h08;
        6'h24, 6'h25, 6'h26: base_curve = 8'h07;
        6'h27, 6'h28, 6'h29, 6'h2A: base_curve = 8'h06;
        6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30: base_curve = 8'h05;
        6'h31, 6'h32, 6'h33, 6'h34, 6'h35: base_curve = 8'h04;
        6'h36, 6'h37, 6'h38: base_curve = 8'h03;
        6'h39, 6'h3A, 6'h3B: base_curve = 8'h02;
        6'h3C, 6'h3D, 6'h3E: base_curve = 8'h01;
        default: base_curve = 8'h00;
      endcase
    end
  endfunction

  function [2:0] att_of;
    input [2:0] s;
    begin
      case (s)
        `STR_AGGRESSIVE: att_of = `ATT_AGGRESSIVE;
        `STR_STRONG:     att_of = `ATT_STRONG;
        `STR_MEDIUM:     att_of = `ATT_MEDIUM;
        `STR_WEAK:       att_of = `ATT_WEAK;
        default:         att_of = `ATT_NONE;
      endcase
    end
  endfunction

  function [7:0] scaled;
    input [5:0] idx;
    input [2:0] s;
    reg   [10:0] p;
    begin
      p = base_curve(idx) * att_of(s);
      scaled = p[9:2];
    end
  endfunction

  integer b;
  integer i;
  reg [2:0] bank_str;
  // Banks 0-4 hold presets; the build-time strength also sits in bank 0
  initial
  begin
    for (b = 0; b < 8; b = b + 1)
    begin
      bank_str = (b == 0) ? INIT_STRENGTH : b[2:0];
      for (i = 0; i < 64; i = i + 1)
      begin
        if (b < 5)
        begin
          luma_mem[b * 64 + i]   = scaled(i[5:0], bank_str);
          chroma_mem[b * 64 + i] = scaled(i[5:0], bank_str);
        end
        else
        begin
          luma_mem[b * 64 + i]   = 8'h00;
          chroma_mem[b * 64 + i] = 8'h00;
        end
      end
    end
  end

  // Overwritten presets stay lost: nothing reloads them
  always @(posedge mclk_i)
  begin
    if (wr_en_i && !wr_chroma_i)
      luma_mem[{wr_bank_i, wr_idx_i}] <= wr_data_i;
    if (wr_en_i && wr_chroma_i)
      chroma_mem[{wr_bank_i, wr_idx_i}] <= wr_data_i;
    rd_luma_o   <= luma_mem[{rd_bank_i, rd_luma_idx_i}];
    rd_chroma_o <= chroma_mem[{rd_bank_i, rd_chroma_idx_i}];
  end

endmodule
`default_nettype wire

// ### rtl/recursive_temporal_denoise.v
`timescale 1ns/10ps
`default_nettype none
`include "rtd_defs.vh"

module recursive_temporal_denoise
#(
  parameter [2:0] INIT_STRENGTH = `STR_AGGRESSIVE
)
(
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire [15:0] curr_tdata_i,
  input  wire        curr_tvalid_i,
  input  wire        curr_tlast_i,
  input  wire        curr_tuser_i,
  output wire        curr_tready_o,
  input  wire [15:0] prev_tdata_i,
  input  wire        prev_tvalid_i,
  output wire        prev_tready_o,
  output reg  [15:0] mem_tdata_o,
  output reg         mem_tvalid_o,
  output reg         mem_tlast_o,
  output reg         mem_tuser_o,
  input  wire        mem_tready_i,
  output reg  [15:0] video_tdata_o,
  output reg         video_tvalid_o,
  output reg         video_tlast_o,
  output reg         video_tuser_o,
  input  wire        video_tready_i,
  output reg  [15:0] motion_tdata_o,
  output reg         motion_tvalid_o,
  output reg         motion_tlast_o,
  output reg         motion_tuser_o,
  input  wire        motion_tready_i,
  input  wire [2:0]  active_bank_i,
  input  wire        curve_wr_en_i,
  input  wire [2:0]  curve_wr_bank_i,
  input  wire        curve_wr_chroma_i,
  input  wire [5:0]  curve_wr_idx_i,
  input  wire [7:0]  curve_wr_data_i,
  input  wire        frame_done_en_i,
  output reg         frame_done_o
);

  // Pair a current and a previous beat only when both are present
  wire pair_ok;
  wire buf_ready;
  assign pair_ok       = curr_tvalid_i && prev_tvalid_i && buf_ready;
  assign curr_tready_o = prev_tvalid_i && buf_ready;
  assign prev_tready_o = curr_tvalid_i && buf_ready;

  wire [7:0] cur_y;
  wire [7:0] cur_c;
  wire [7:0] prv_y;
  wire [7:0] prv_c;
  assign cur_y = curr_tdata_i[`LUMA_LSB +: 8];
  assign cur_c = curr_tdata_i[`CHROMA_LSB +: 8];
  assign prv_y = prev_tdata_i[`LUMA_LSB +: 8];
  assign prv_c = prev_tdata_i[`CHROMA_LSB +: 8];

  function [7:0] absdiff;
    input [7:0] a;
    input [7:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // Stage 1: absolute differences and FIR history
  reg  [7:0]  s1_cy_r;
  reg  [7:0]  s1_cc_r;
  reg  [7:0]  s1_py_r;
  reg  [7:0]  s1_pc_r;
  reg         s1_last_r;
  reg         s1_sof_r;
  reg         s1_v_r;
  reg  [7:0]  dy0_r;
  reg  [7:0]  dy1_r;
  reg  [7:0]  dy2_r;
  reg  [7:0]  dcb_r;
  reg  [7:0]  dcr_r;
  reg  [7:0]  dcprev_r;
  reg  [7:0]  mot_y_r;
  reg  [7:0]  mot_c_r;
  reg         cphase_r;

  wire [7:0]  dy_new;
  wire [7:0]  dc_new;
  wire [9:0]  fir_y;
  wire [9:0]  fir_c;
  assign dy_new = absdiff(cur_y, prv_y);
  assign dc_new = absdiff(cur_c, prv_c);
  // Luma (1,2,1)/4 over neighbours; chroma: new sample, 2x older and 1x latest of the other component
  assign fir_y = {2'b00, dy_new} + {1'b0, dy0_r, 1'b0} + {2'b00, dy1_r};
  assign fir_c = {2'b00, dc_new} + {1'b0, dcprev_r, 1'b0}
               + {2'b00, (cphase_r ? dcb_r : dcr_r)};

  wire [7:0] fy_sat;
  wire [7:0] fc_sat;
  assign fy_sat = fir_y[9:`FIR_SHIFT];
  assign fc_sat = fir_c[9:`FIR_SHIFT];

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s1_v_r    <= 1'b0;
      s1_last_r <= 1'b0;
      s1_sof_r  <= 1'b0;
      s1_cy_r   <= 8'h00;
      s1_cc_r   <= 8'h00;
      s1_py_r   <= 8'h00;
      s1_pc_r   <= 8'h00;
      dy0_r     <= 8'h00;
      dy1_r     <= 8'h00;
      dy2_r     <= 8'h00;
      dcb_r     <= 8'h00;
      dcr_r     <= 8'h00;
      dcprev_r  <= 8'h00;
      mot_y_r   <= 8'h00;
      mot_c_r   <= 8'h00;
      cphase_r  <= 1'b0;
    end
    else if (buf_ready)
    begin
      s1_v_r <= pair_ok;
      if (pair_ok)
      begin
        s1_cy_r   <= cur_y;
        s1_cc_r   <= cur_c;
        s1_py_r   <= prv_y;
        s1_pc_r   <= prv_c;
        s1_last_r <= curr_tlast_i;
        s1_sof_r  <= curr_tuser_i;
        dy1_r     <= dy0_r;
        dy0_r     <= dy_new;
        dy2_r     <= dy1_r;
        dcprev_r  <= cphase_r ? dcr_r : dcb_r;
        if (cphase_r)
          dcr_r <= dc_new;
        else
          dcb_r <= dc_new;
        cphase_r  <= curr_tlast_i ? 1'b0 : ~cphase_r;
        mot_y_r   <= fy_sat;
        mot_c_r   <= fc_sat;
        // Smoothing restarts on each line, as does the chroma phase
        if (curr_tlast_i)
        begin
          dy0_r    <= 8'h00;
          dy1_r    <= 8'h00;
          dcb_r    <= 8'h00;
          dcr_r    <= 8'h00;
          dcprev_r <= 8'h00;
        end
      end
    end
  end

  reg [2:0] frame_bank_r;
  always @(posedge mclk_i)
  begin
    if (rst_i)
      frame_bank_r <= `ACTIVE_BANK_RST;
    else if (pair_ok && curr_tuser_i)
      frame_bank_r <= active_bank_i;
  end

  // Curve lookup, indexed by 6-bit motion; a held stage re-reads its own
  wire [5:0] idx_y;
  wire [5:0] idx_c;
  wire [5:0] new_idx_y;
  wire [5:0] new_idx_c;
  wire [5:0] rd_idx_y;
  wire [5:0] rd_idx_c;
  wire [2:0] rd_bank;
  assign idx_y = (mot_y_r[7:6] != 2'b00) ? `CURVE_LAST_IDX : mot_y_r[5:0];
  assign idx_c = (mot_c_r[7:6] != 2'b00) ? `CURVE_LAST_IDX : mot_c_r[5:0];
  assign new_idx_y = (fy_sat[7:6] != 2'b00) ? `CURVE_LAST_IDX : fy_sat[5:0];
  assign new_idx_c = (fc_sat[7:6] != 2'b00) ? `CURVE_LAST_IDX : fc_sat[5:0];
  assign rd_idx_y = pair_ok ? new_idx_y : idx_y;
  assign rd_idx_c = pair_ok ? new_idx_c : idx_c;
  // The first pixel of a frame already reads from the newly chosen bank
  assign rd_bank = (pair_ok && curr_tuser_i) ? active_bank_i
                                             : frame_bank_r;

  wire [7:0] k_y;
  wire [7:0] k_c;

  curve_mem #(
    .INIT_STRENGTH (INIT_STRENGTH)
  ) u_curve (
    .mclk_i          (mclk_i),
    .wr_en_i         (curve_wr_en_i),
    .wr_bank_i       (curve_wr_bank_i),
    .wr_chroma_i     (curve_wr_chroma_i),
    .wr_idx_i        (curve_wr_idx_i),
    .wr_data_i       (curve_wr_data_i),
    .rd_bank_i       (rd_bank),
    .rd_luma_idx_i   (rd_idx_y),
    .rd_chroma_idx_i (rd_idx_c),
    .rd_luma_o       (k_y),
    .rd_chroma_o     (k_c)
  );

  // Blend: cur + k*(prev-cur)/256, rounded and clamped
  function [7:0] blend;
    input [7:0] c;
    input [7:0] p;
    input [7:0] k;
    reg signed [8:0]  d;
    reg signed [17:0] m;
    reg signed [10:0] r;
    begin
      d = $signed({1'b0, p}) - $signed({1'b0, c});
      m = d * $signed({1'b0, k});
      m = m + 18'sd128;
      r = $signed({1'b0, c, 2'b00}) / 4 + $signed(m[17:8]);
      if (k == 8'h00)
        blend = c;
      else if (r < 0)
        blend = 8'h00;
      else if (r > 255)
        blend = 8'hFF;
      else
        blend = r[7:0];
    end
  endfunction

  wire [7:0] out_y;
  wire [7:0] out_c;
  assign out_y = blend(s1_cy_r, s1_py_r, k_y);
  assign out_c = blend(s1_cc_r, s1_pc_r, k_c);

  // One-entry output register feeding three outputs in lockstep
  reg  [49:0] ent0_r;
  reg  [49:0] ent1_r;
  reg  [1:0]  cnt_r;
  wire [49:0] in_word;
  wire        out_take;
  wire        in_push;
  assign in_word  = {s1_sof_r, s1_last_r, mot_c_r, mot_y_r, 16'h0000,
                     out_c, out_y};
  assign in_push  = s1_v_r && buf_ready;
  assign out_take = mem_tvalid_o && mem_tready_i && video_tready_i
                    && motion_tready_i;
  assign buf_ready = (cnt_r == 2'd0);

  reg [1:0] cnt_nxt;
  always @*
  begin
    cnt_nxt = cnt_r;
    if (in_push && !out_take)
      cnt_nxt = cnt_r + 2'd1;
    else if (!in_push && out_take)
      cnt_nxt = cnt_r - 2'd1;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cnt_r           <= 2'd0;
      ent0_r          <= 50'h0;
      ent1_r          <= 50'h0;
      mem_tdata_o     <= 16'h0000;
      mem_tvalid_o    <= 1'b0;
      mem_tlast_o     <= 1'b0;
      mem_tuser_o     <= 1'b0;
      video_tdata_o   <= 16'h0000;
      video_tvalid_o  <= 1'b0;
      video_tlast_o   <= 1'b0;
      video_tuser_o   <= 1'b0;
      motion_tdata_o  <= 16'h0000;
      motion_tvalid_o <= 1'b0;
      motion_tlast_o  <= 1'b0;
      motion_tuser_o  <= 1'b0;
      frame_done_o    <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      frame_done_o <= 1'b0;
      if (in_push)
        ent0_r <= in_word;
      if (out_take || !mem_tvalid_o)
      begin
        mem_tvalid_o    <= in_push;
        video_tvalid_o  <= in_push;
        motion_tvalid_o <= in_push;
        if (in_push)
        begin
          mem_tdata_o    <= {out_c, out_y};
          video_tdata_o  <= {out_c, out_y};
          motion_tdata_o <= {mot_c_r, mot_y_r};
          mem_tlast_o    <= s1_last_r;
          video_tlast_o  <= s1_last_r;
          motion_tlast_o <= s1_last_r;
          mem_tuser_o    <= s1_sof_r;
          video_tuser_o  <= s1_sof_r;
          motion_tuser_o <= s1_sof_r;
        end
      end
      if (out_take && mem_tuser_o && frame_done_en_i)
        frame_done_o <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### rtl/rtd_defs.vh
`ifndef RTD_DEFS_VH
`define RTD_DEFS_VH

// Curve memory geometry
`define CURVE_ENTRIES    64
`define CURVE_IDX_W      6
`define CURVE_BANKS      8
`define BANK_W           3
`define CURVE_LAST_IDX   6'h3F

// Preset strength codes (build-time choice and bank numbers)
`define STR_AGGRESSIVE   3'h0
`define STR_STRONG       3'h1
`define STR_MEDIUM       3'h2
`define STR_WEAK         3'h3
`define STR_NONE         3'h4

// Attenuation numerators over 4
`define ATT_AGGRESSIVE   3'h4
`define ATT_STRONG       3'h3
`define ATT_MEDIUM       3'h2
`define ATT_WEAK         3'h1
`define ATT_NONE         3'h0

// Stream byte lanes
`define LUMA_LSB         0
`define CHROMA_LSB       8

// Motion FIR taps (1,2,1)/4
`define FIR_SHIFT        2

// Reset values
`define ACTIVE_BANK_RST  3'h0

`endif
